/* rctd_regs.v */
`timescale 1ns/100ps
`include "rctd_defines.vh"

module rctd_regs #(
  parameter NGROUPS = 64
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt
  output wire irq,
  // Sleep timer
  input wire lp_clk,
  output reg sleep_wake_interrupt,
  // Corrections
  output wire [9:0] fine_phase_corr,
  output wire [26:0] base_time_corr_value,
  // Probe ports
  input wire [NGROUPS*8-1:0] probe_src,
  output wire [7:0] probe_bus_0,
  output wire [7:0] probe_bus_1,
  output wire [7:0] probe_bus_2,
  output wire [7:0] probe_bus_3,
  // Zone watch
  input wire reg_acc_valid,
  input wire [15:0] reg_acc_addr,
  input wire xmem_acc_valid,
  input wire [15:0] xmem_acc_addr,
  output reg regzone_hit_flag,
  output reg xmem_zone_hit_flag,
  // Link layer checks
  input wire event_irq,
  input wire event_irq_ack,
  input wire [2:0] event_mode,
  input wire [7:0] pkt_len,
  input wire rx_buf_check,
  input wire [15:0] rx_buf_ptr,
  input wire tx_buf_check,
  input wire [15:0] tx_buf_ptr,
  input wire rx_desc_check,
  input wire [14:0] rx_desc_ptr,
  input wire tx_desc_check,
  input wire [15:0] tx_desc_ptr
);

  ////////////////////////////////////////////////////////////////////////////
  function in_zone;
    input [15:0] addr;
    input [15:0] lower;
    input [15:0] upper;
    begin
      in_zone = (addr >= lower) && (addr <= upper);
    end
  endfunction

  // Four fixed ports; the control word holds one byte per port
  localparam NPORTS = 4;

  reg [31:0] lead_reg;
  reg [9:0] fine_reg;
  reg [26:0] base_reg;
  reg [31:0] pctl_reg;
  reg [31:0] zmax_reg;
  reg [31:0] zmin_reg;
  reg [31:0] sleep_reg;
  reg [`RCTD_EV_WIDTH-1:0] istat_reg;
  reg [`RCTD_EV_WIDTH-1:0] imask_reg;
  reg ovl_err_reg;
  reg rxb_err_reg;
  reg txb_err_reg;
  reg rxd_err_reg;
  reg txd_err_reg;
  reg pend_reg;
  reg running_reg;
  reg [31:0] remain_reg;
  reg [7:0] probe_reg [0:3];
  reg lp_s1_reg;
  reg lp_s2_reg;
  reg lp_s3_reg;
  reg hit;
  reg [31:0] rd_next;

  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite & hit;
  // Live bus values, not a stored copy
  wire [31:0] readback = {probe_bus_3, probe_bus_2, probe_bus_1, probe_bus_0};
  wire [31:0] err_word = {14'h0000, ovl_err_reg, rxb_err_reg, txb_err_reg,
                          rxd_err_reg, txd_err_reg, 13'h0000};
  wire [10:0] set_lead = lead_reg[`RCTD_SET_LEAD_MSB:`RCTD_SET_LEAD_LSB];
  wire [9:0] clr_lead = lead_reg[`RCTD_CLR_LEAD_MSB:`RCTD_CLR_LEAD_LSB];

  // Zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign irq = |(istat_reg & imask_reg);

  assign fine_phase_corr = fine_reg;
  assign base_time_corr_value = base_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux
  always @* begin
    hit = 1'b1;
    rd_next = 32'h00000000;
    if (paddr == `RCTD_LEAD_ADDR) begin
      rd_next = {11'h000, lead_reg[`RCTD_SET_LEAD_MSB:0]};
    end else if (paddr == `RCTD_FINE_ADDR) begin
      rd_next = {22'h000000, fine_reg};
    end else if (paddr == `RCTD_BASE_ADDR) begin
      rd_next = {5'h00, base_reg};
    end else if (paddr == `RCTD_PCTL_ADDR) begin
      rd_next = pctl_reg;
    end else if (paddr == `RCTD_PRBK_ADDR) begin
      rd_next = readback;
    end else if (paddr == `RCTD_ZMAX_ADDR) begin
      rd_next = zmax_reg;
    end else if (paddr == `RCTD_ZMIN_ADDR) begin
      rd_next = zmin_reg;
    end else if (paddr == `RCTD_ERR_ADDR) begin
      rd_next = err_word;
    end else if (paddr == `RCTD_SLEEP_ADDR) begin
      rd_next = sleep_reg;
    end else if (paddr == `RCTD_SCTL_ADDR) begin
      rd_next = {30'h00000000, running_reg, 1'b0};
    end else if (paddr == `RCTD_ISTAT_ADDR) begin
      rd_next = {29'h00000000, istat_reg};
    end else if (paddr == `RCTD_IMASK_ADDR) begin
      rd_next = {29'h00000000, imask_reg};
    end else begin
      hit = 1'b0;
    end
  end

  // Read data captured in setup so it stands registered during access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RCTD_RESET_WORD;
    end else if (setup) begin
      prdata <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_reg <= `RCTD_RESET_WORD;
      fine_reg <= 10'h000;
      base_reg <= 27'h0000000;
      pctl_reg <= `RCTD_RESET_WORD;
      zmax_reg <= `RCTD_RESET_WORD;
      zmin_reg <= `RCTD_RESET_WORD;
      sleep_reg <= `RCTD_RESET_WORD;
      imask_reg <= `RCTD_RESET_EV;
    end else if (wr) begin
      // read-only words not decoded for write
      if (paddr == `RCTD_LEAD_ADDR) begin
        lead_reg <= {11'h000, pwdata[`RCTD_SET_LEAD_MSB:0]};
      end else if (paddr == `RCTD_FINE_ADDR) begin
        fine_reg <= pwdata[`RCTD_FINE_MSB:0];
      end else if (paddr == `RCTD_BASE_ADDR) begin
        base_reg <= pwdata[`RCTD_BASE_MSB:0];
      end else if (paddr == `RCTD_PCTL_ADDR) begin
        pctl_reg <= pwdata & 32'hbfbfbfbf;
      end else if (paddr == `RCTD_ZMAX_ADDR) begin
        zmax_reg <= pwdata;
      end else if (paddr == `RCTD_ZMIN_ADDR) begin
        zmin_reg <= pwdata;
      end else if (paddr == `RCTD_SLEEP_ADDR) begin
        sleep_reg <= pwdata;
      end else if (paddr == `RCTD_IMASK_ADDR) begin
        imask_reg <= pwdata[`RCTD_EV_WIDTH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Probe ports
  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : g_probe
      wire en = pctl_reg[8*g+`RCTD_PEN_BIT];
      wire [5:0] sel = pctl_reg[8*g+`RCTD_PSEL_MSB -: 6];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          probe_reg[g] <= 8'h00;
        end else if (!en) begin
          probe_reg[g] <= 8'h00;
        end else if (sel < NGROUPS) begin
          probe_reg[g] <= probe_src[8*sel +: 8];
        end else begin
          probe_reg[g] <= 8'h00;
        end
      end
    end
  endgenerate

  assign probe_bus_0 = probe_reg[0];
  assign probe_bus_1 = probe_reg[1];
  assign probe_bus_2 = probe_reg[2];
  assign probe_bus_3 = probe_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // Zone flags, one cycle after the access
  wire [15:0] reg_lower = zmin_reg[`RCTD_UPPER_MSB:`RCTD_UPPER_LSB];
  wire [15:0] reg_upper = zmax_reg[`RCTD_UPPER_MSB:`RCTD_UPPER_LSB];
  wire [15:0] xmem_lower = zmin_reg[`RCTD_LOWER_MSB:`RCTD_LOWER_LSB];
  wire [15:0] xmem_upper = zmax_reg[`RCTD_LOWER_MSB:`RCTD_LOWER_LSB];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regzone_hit_flag <= 1'b0;
      xmem_zone_hit_flag <= 1'b0;
    end else begin
      regzone_hit_flag <= reg_acc_valid & in_zone(reg_acc_addr,
        reg_lower, reg_upper);
      xmem_zone_hit_flag <= xmem_acc_valid & in_zone(xmem_acc_addr,
        xmem_lower, xmem_upper);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming error flags, sticky until reset
  // Read-only by design: a fault seen once stays visible
  // however late software gets round to looking
  wire tx_mode_adv = (event_mode == `RCTD_MODE_ADV) || (event_mode == `RCTD_MODE_SCAN) ||
                     (event_mode == `RCTD_MODE_INIT);
  wire tx_mode_conn = (event_mode == `RCTD_MODE_MASTER) || (event_mode == `RCTD_MODE_SLAVE);
  wire ovl_set = event_irq & pend_reg & ~event_irq_ack;
  wire rxb_set = rx_buf_check & (rx_buf_ptr == 16'h0000);
  wire txb_set = tx_buf_check & (tx_buf_ptr == 16'h0000) &
                 (tx_mode_adv | (tx_mode_conn & (pkt_len != 8'h00)));
  wire rxd_set = rx_desc_check & (rx_desc_ptr == 15'h0000);
  wire txd_set = tx_desc_check & (tx_desc_ptr == 16'h0000) & tx_mode_adv;
  wire err_event = (ovl_set & ~ovl_err_reg) | (rxb_set & ~rxb_err_reg) |
                   (txb_set & ~txb_err_reg) | (rxd_set & ~rxd_err_reg) |
                   (txd_set & ~txd_err_reg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      ovl_err_reg <= 1'b0;
      rxb_err_reg <= 1'b0;
      txb_err_reg <= 1'b0;
      rxd_err_reg <= 1'b0;
      txd_err_reg <= 1'b0;
    end else begin
      // New event interrupt wins over an acknowledge in the same cycle
      if (event_irq) begin
        pend_reg <= 1'b1;
      end else if (event_irq_ack) begin
        pend_reg <= 1'b0;
      end
      if (ovl_set) begin
        ovl_err_reg <= 1'b1;
      end
      if (rxb_set) begin
        rxb_err_reg <= 1'b1;
      end
      if (txb_set) begin
        txb_err_reg <= 1'b1;
      end
      if (rxd_set) begin
        rxd_err_reg <= 1'b1;
      end
      if (txd_set) begin
        txd_err_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power clock synchroniser and tick edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_s1_reg <= 1'b0;
      lp_s2_reg <= 1'b0;
      lp_s3_reg <= 1'b0;
    end else begin
      lp_s1_reg <= lp_clk;
      lp_s2_reg <= lp_s1_reg;
      lp_s3_reg <= lp_s2_reg;
    end
  end

  // Needs pclk well above twice the low-power clock rate
  wire lp_tick = lp_s2_reg & ~lp_s3_reg;
  wire start = wr && (paddr == `RCTD_SCTL_ADDR) && pwdata[`RCTD_SCTL_START_BIT];
  wire [31:0] remain_dec = remain_reg - 32'h00000001;
  // A start landing on a tick restarts the count; that tick must not
  // raise the old sleep's expiry or wake events
  wire tick_live = running_reg & lp_tick & ~start;
  wire expire = tick_live & (remain_dec == 32'h00000000);
  wire wake_rise = tick_live & ~sleep_wake_interrupt &
                   (remain_dec == {21'h000000, set_lead});

  ////////////////////////////////////////////////////////////////////////////
  // Sleep countdown and wake interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_reg <= 1'b0;
      remain_reg <= `RCTD_RESET_WORD;
      sleep_wake_interrupt <= 1'b0;
    end else if (start) begin
      running_reg <= (sleep_reg != 32'h00000000);
      remain_reg <= sleep_reg;
      sleep_wake_interrupt <= 1'b0;
    end else if (running_reg && lp_tick) begin
      remain_reg <= remain_dec;
      if (expire) begin
        running_reg <= 1'b0;
      end
      if (remain_dec == {22'h000000, clr_lead} || expire) begin
        sleep_wake_interrupt <= 1'b0;
      end else if (wake_rise) begin
        sleep_wake_interrupt <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; a new event wins over the clear
  wire [`RCTD_EV_WIDTH-1:0] ev_set = {err_event, expire, wake_rise};
  wire [`RCTD_EV_WIDTH-1:0] ev_clr = (wr && paddr == `RCTD_ISTAT_ADDR) ?
                                     pwdata[`RCTD_EV_WIDTH-1:0] : `RCTD_RESET_EV;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= `RCTD_RESET_EV;
    end else begin
      istat_reg <= (istat_reg & ~ev_clr) | ev_set;
    end
  end

endmodule // rctd_regs

/* rctd_defines.vh */
`ifndef RCTD_DEFINES_VH
`define RCTD_DEFINES_VH

// Register byte addresses
`define RCTD_LEAD_ADDR 32'h4000003c
`define RCTD_FINE_ADDR 32'h40000040
`define RCTD_BASE_ADDR 32'h40000044
`define RCTD_PCTL_ADDR 32'h40000050
`define RCTD_PRBK_ADDR 32'h40000054
`define RCTD_ZMAX_ADDR 32'h40000058
`define RCTD_ZMIN_ADDR 32'h4000005c
`define RCTD_ERR_ADDR 32'h40000060
`define RCTD_SLEEP_ADDR 32'h40000100
`define RCTD_SCTL_ADDR 32'h40000104
`define RCTD_ISTAT_ADDR 32'h40000108
`define RCTD_IMASK_ADDR 32'h4000010c

// Field positions
`define RCTD_SET_LEAD_MSB 20
`define RCTD_SET_LEAD_LSB 10
`define RCTD_CLR_LEAD_MSB 9
`define RCTD_CLR_LEAD_LSB 0
`define RCTD_FINE_MSB 9
`define RCTD_BASE_MSB 26
`define RCTD_PEN_BIT 7
`define RCTD_PSEL_MSB 5
`define RCTD_UPPER_MSB 31
`define RCTD_UPPER_LSB 16
`define RCTD_LOWER_MSB 15
`define RCTD_LOWER_LSB 0
`define RCTD_ERR_OVL_BIT 17
`define RCTD_ERR_RXB_BIT 16
`define RCTD_ERR_TXB_BIT 15
`define RCTD_ERR_RXD_BIT 14
`define RCTD_ERR_TXD_BIT 13
`define RCTD_SCTL_START_BIT 0
`define RCTD_SCTL_RUN_BIT 1
`define RCTD_EV_WAKE_BIT 0
`define RCTD_EV_EXPIRE_BIT 1
`define RCTD_EV_ERR_BIT 2
`define RCTD_EV_WIDTH 3

// Reset values
`define RCTD_RESET_WORD 32'h00000000
`define RCTD_RESET_EV 3'h0

// Link event types
`define RCTD_MODE_ADV 3'h0
`define RCTD_MODE_SCAN 3'h1
`define RCTD_MODE_INIT 3'h2
`define RCTD_MODE_MASTER 3'h3
`define RCTD_MODE_SLAVE 3'h4

`endif

/* rctd_lp_model.sv */
`timescale 1ns/100ps

module rctd_lp_model (
  // Low-power clock
  output reg lp_clk
);
  initial lp_clk = 1'b0;

  // counted sleep ticks
  // Held still between bursts so every tick is deliberate
  task automatic tick(input int n);
    repeat (n) begin
      #370 lp_clk = 1'b1;
      #370 lp_clk = 1'b0;
    end
  endtask
endmodule // rctd_lp_model

/* rctd_monitor.sv */
`timescale 1ns/100ps
`include "rctd_defines.vh"

module rctd_monitor #(
  parameter NGROUPS = 64
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Corrections
  input wire [9:0] fine_phase_corr,
  input wire [26:0] base_time_corr_value,
  // Probes
  input wire [NGROUPS*8-1:0] probe_src,
  input wire [7:0] probe_bus_0,
  input wire [7:0] probe_bus_1,
  input wire [7:0] probe_bus_2,
  input wire [7:0] probe_bus_3,
  // Zones
  input wire reg_acc_valid,
  input wire [15:0] reg_acc_addr,
  input wire xmem_acc_valid,
  input wire [15:0] xmem_acc_addr,
  input wire regzone_hit_flag,
  input wire xmem_zone_hit_flag
);
  reg [31:0] pctl_reg;
  reg [31:0] zmax_reg;
  reg [31:0] zmin_reg;
  wire wr_acc = psel && penable && pwrite;
  wire [7:0] src0 = probe_src[8*pctl_reg[5:0] +: 8];
  wire in_reg = reg_acc_addr >= zmin_reg[31:16] && reg_acc_addr <= zmax_reg[31:16];
  wire in_xm = xmem_acc_addr >= zmin_reg[15:0] && xmem_acc_addr <= zmax_reg[15:0];

  // Shadow copies, updated at the same edge as the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pctl_reg <= 32'h0;
      zmax_reg <= 32'h0;
      zmin_reg <= 32'h0;
    end else if (wr_acc) begin
      if (paddr == `RCTD_PCTL_ADDR) pctl_reg <= pwdata;
      if (paddr == `RCTD_ZMAX_ADDR) zmax_reg <= pwdata;
      if (paddr == `RCTD_ZMIN_ADDR) zmin_reg <= pwdata;
    end
  end

  ////////////////////////////////////////
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_fine;
    wr_acc && paddr == `RCTD_FINE_ADDR;
  endsequence
  sequence s_wr_base;
    wr_acc && paddr == `RCTD_BASE_ADDR;
  endsequence
  sequence s_rd_rbk;
    psel && penable && !pwrite && paddr == `RCTD_PRBK_ADDR;
  endsequence

  property p_fine;
    s_wr_fine |=> fine_phase_corr == $past(pwdata[9:0]);
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine correction not loaded");
  property p_base;
    s_wr_base |=> base_time_corr_value == $past(pwdata[26:0]);
  endproperty
  a_base: assert property (p_base)
    else $error("base correction not loaded");
  property p_off0;
    !pctl_reg[7] |=> probe_bus_0 == 8'h00;
  endproperty
  a_off0: assert property (p_off0)
    else $error("disabled port 0 not zero");
  property p_off3;
    !pctl_reg[31] |=> probe_bus_3 == 8'h00;
  endproperty
  a_off3: assert property (p_off3)
    else $error("disabled port 3 not zero");
  property p_sel0;
    pctl_reg[7] |=> probe_bus_0 == $past(src0);
  endproperty
  a_sel0: assert property (p_sel0)
    else $error("port 0 shows wrong group");
  property p_rbk;
    s_rd_rbk |-> prdata == $past({probe_bus_3, probe_bus_2, probe_bus_1, probe_bus_0});
  endproperty
  a_rbk: assert property (p_rbk)
    else $error("readback word differs from buses");
  property p_rzone;
    reg_acc_valid |=> regzone_hit_flag == $past(in_reg);
  endproperty
  a_rzone: assert property (p_rzone)
    else $error("register zone flag wrong");
  property p_xzone;
    xmem_acc_valid |=> xmem_zone_hit_flag == $past(in_xm);
  endproperty
  a_xzone: assert property (p_xzone)
    else $error("exchange zone flag wrong");
endmodule // rctd_monitor

bind rctd_regs rctd_monitor #(.NGROUPS(NGROUPS)) rctd_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .fine_phase_corr(fine_phase_corr),
  .base_time_corr_value(base_time_corr_value), .probe_src(probe_src),
  .probe_bus_0(probe_bus_0), .probe_bus_1(probe_bus_1), .probe_bus_2(probe_bus_2),
  .probe_bus_3(probe_bus_3), .reg_acc_valid(reg_acc_valid), .reg_acc_addr(reg_acc_addr),
  .xmem_acc_valid(xmem_acc_valid), .xmem_acc_addr(xmem_acc_addr),
  .regzone_hit_flag(regzone_hit_flag), .xmem_zone_hit_flag(xmem_zone_hit_flag)
);

/* rctd_regs_tb_top.sv */
`timescale 1ns/100ps
`include "rctd_defines.vh"

module rctd_regs_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [31:0] paddr = 32'h0, pwdata = 32'h0;
  reg [511:0] probe_src = 512'h0;
  reg reg_acc_valid = 1'b0, xmem_acc_valid = 1'b0;
  reg event_irq = 1'b0, event_irq_ack = 1'b0;
  reg rx_buf_check = 1'b0, tx_buf_check = 1'b0;
  reg rx_desc_check = 1'b0, tx_desc_check = 1'b0;
  reg [15:0] reg_acc_addr = 16'h0, xmem_acc_addr = 16'h0;
  reg [15:0] rx_buf_ptr = 16'h0, tx_buf_ptr = 16'h0, tx_desc_ptr = 16'h0;
  reg [14:0] rx_desc_ptr = 15'h0;
  reg [2:0] event_mode = 3'h0;
  reg [7:0] pkt_len = 8'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, lp_clk, sleep_wake_interrupt;
  wire regzone_hit_flag, xmem_zone_hit_flag;
  wire [9:0] fine_phase_corr;
  wire [26:0] base_time_corr_value;
  wire [7:0] probe_bus_0, probe_bus_1, probe_bus_2, probe_bus_3;
  int fails = 0;
  int n_tests = 0;
  logic [31:0] q, c, e;
  logic [511:0] ps;
  logic se;
  int dz[7] = '{-1, 0, 50, 100, 101, 150, 151};
  logic [31:0] ra[6] = '{`RCTD_LEAD_ADDR, `RCTD_FINE_ADDR, `RCTD_BASE_ADDR,
    `RCTD_PCTL_ADDR, `RCTD_ZMAX_ADDR, `RCTD_ZMIN_ADDR};
  logic [31:0] rm[6] = '{32'h001fffff, 32'h000003ff, 32'h07ffffff,
    32'hbfbfbfbf, 32'hffffffff, 32'hffffffff};

  always #50 pclk = ~pclk;

  rctd_regs rctd_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .lp_clk(lp_clk),
    .sleep_wake_interrupt(sleep_wake_interrupt), .fine_phase_corr(fine_phase_corr),
    .base_time_corr_value(base_time_corr_value), .probe_src(probe_src),
    .probe_bus_0(probe_bus_0), .probe_bus_1(probe_bus_1), .probe_bus_2(probe_bus_2),
    .probe_bus_3(probe_bus_3), .reg_acc_valid(reg_acc_valid), .reg_acc_addr(reg_acc_addr),
    .xmem_acc_valid(xmem_acc_valid), .xmem_acc_addr(xmem_acc_addr),
    .regzone_hit_flag(regzone_hit_flag), .xmem_zone_hit_flag(xmem_zone_hit_flag),
    .event_irq(event_irq), .event_irq_ack(event_irq_ack), .event_mode(event_mode),
    .pkt_len(pkt_len), .rx_buf_check(rx_buf_check), .rx_buf_ptr(rx_buf_ptr),
    .tx_buf_check(tx_buf_check), .tx_buf_ptr(tx_buf_ptr), .rx_desc_check(rx_desc_check),
    .rx_desc_ptr(rx_desc_ptr), .tx_desc_check(tx_desc_check), .tx_desc_ptr(tx_desc_ptr)
  );
  rctd_lp_model rctd_lp_model_i (.lp_clk(lp_clk));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] x, s);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask

  function automatic logic [7:0] pexp(input logic [31:0] w, input int g);
    logic [7:0] b;
    b = w[8*g +: 8];
    return b[7] ? probe_src[8*b[5:0] +: 8] : 8'h00;
  endfunction

  function automatic logic [31:0] errx(input logic [1:0] s, input logic [2:0] m,
      input logic [7:0] n, input logic [15:0] p);
    if (p != 16'h0) return 32'h0;
    case (s)
      2'd0: return 32'h00010000;
      2'd1: return (m <= `RCTD_MODE_INIT || n != 8'h0) ? 32'h00008000 : 32'h0;
      2'd2: return 32'h00004000;
      default: return m <= `RCTD_MODE_INIT ? 32'h00002000 : 32'h0;
    endcase
  endfunction

  task automatic lnk(input logic [1:0] s, input logic [2:0] m, input logic [7:0] n,
      input logic [15:0] p);
    event_mode <= m;
    pkt_len <= n;
    rx_buf_ptr <= p;
    tx_buf_ptr <= p;
    rx_desc_ptr <= p[14:0];
    tx_desc_ptr <= p;
    {tx_desc_check, rx_desc_check, tx_buf_check, rx_buf_check} <= 4'h1 << s;
    @(posedge pclk);
    {tx_desc_check, rx_desc_check, tx_buf_check, rx_buf_check} <= 4'h0;
    @(posedge pclk);
    e |= errx(s, m, n, p);
  endtask

  task automatic ev(input logic i, a);
    event_irq <= i;
    event_irq_ack <= a;
    @(posedge pclk);
  endtask

  task automatic print_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    #2000000;
    fails++;
    $display("[ERR] watchdog exp done got timeout");
    print_verdict;
  end

  initial begin
    void'($urandom(8));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) begin
      c = $urandom;
      rd("reset", ra[i], 32'h0);
      apb(1'b1, ra[i], c);
      rd("rw", ra[i], c & rm[i]);
    end
    apb(1'b1, `RCTD_ERR_ADDR, 32'h0003e000);
    rd("err ro", `RCTD_ERR_ADDR, 32'h0);
    apb(1'b0, 32'h40000070, 32'h0);
    chk("slverr", 32'h1, se);
    chk("unmapped", 32'h0, q);
    $display("test regs done");
    for (int i = 0; i < 16; i++) ps[32*i +: 32] = $urandom;
    probe_src <= ps;
    for (int j = 0; j < 2; j++) begin
      c = j ? c ^ 32'h80000080 : $urandom & 32'h3fbfbfbf | 32'h80;
      apb(1'b1, `RCTD_PCTL_ADDR, c);
      e = {pexp(c, 3), pexp(c, 2), pexp(c, 1), pexp(c, 0)};
      @(negedge pclk);
      chk("probe", e, {probe_bus_3, probe_bus_2, probe_bus_1, probe_bus_0});
      @(posedge pclk);
      rd("readback", `RCTD_PRBK_ADDR, e);
      apb(1'b1, `RCTD_PRBK_ADDR, 32'hffffffff);
      rd("readback ro", `RCTD_PRBK_ADDR, e);
    end
    $display("test probes done");
    c = $urandom % 1000 + 10;
    apb(1'b1, `RCTD_ZMIN_ADDR, {c[15:0], c[15:0] + 16'd50});
    apb(1'b1, `RCTD_ZMAX_ADDR, {c[15:0] + 16'd100, c[15:0] + 16'd150});
    foreach (dz[i]) begin
      reg_acc_valid <= 1'b1;
      xmem_acc_valid <= 1'b1;
      reg_acc_addr <= c[15:0] + dz[i];
      xmem_acc_addr <= c[15:0] + dz[i];
      @(posedge pclk);
      reg_acc_valid <= 1'b0;
      xmem_acc_valid <= 1'b0;
      @(negedge pclk);
      chk("regzone", dz[i] >= 0 && dz[i] <= 100, regzone_hit_flag);
      chk("xzone", dz[i] >= 50 && dz[i] <= 150, xmem_zone_hit_flag);
      @(posedge pclk);
    end
    $display("test zones done");
    e = 32'h0;
    lnk(2'd1, `RCTD_MODE_MASTER, 8'h0, 16'h0);
    lnk(2'd3, `RCTD_MODE_SLAVE, 8'h9, 16'h0);
    rd("err none", `RCTD_ERR_ADDR, 32'h0);
    repeat (30) begin
      c = $urandom;
      lnk(c[1:0], c[4:2] % 5, c[5] ? c[15:8] : 8'h0, c[7:6] == 0 ? 16'h0 : c[31:16] | 16'h1);
      rd("err", `RCTD_ERR_ADDR, e);
    end
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b1);
    ev(1'b0, 1'b0);
    rd("overlap none", `RCTD_ERR_ADDR, e);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b0);
    rd("overlap", `RCTD_ERR_ADDR, e | 32'h00020000);
    $display("test errors done");
    apb(1'b1, `RCTD_IMASK_ADDR, 32'h2);
    // set lead above clear lead of one
    apb(1'b1, `RCTD_LEAD_ADDR, 32'h00000c01);
    apb(1'b1, `RCTD_SLEEP_ADDR, 32'h8);
    apb(1'b1, `RCTD_ISTAT_ADDR, 32'h7);
    apb(1'b1, `RCTD_SCTL_ADDR, 32'h1);
    rd("running", `RCTD_SCTL_ADDR, 32'h2);
    for (int t = 1; t <= 8; t++) begin
      rctd_lp_model_i.tick(1);
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk("wake", t >= 5 && t < 7, sleep_wake_interrupt);
      chk("irq", t == 8, irq);
      @(posedge pclk);
    end
    rd("stopped", `RCTD_SCTL_ADDR, 32'h0);
    rd("status", `RCTD_ISTAT_ADDR, 32'h3);
    apb(1'b1, `RCTD_ISTAT_ADDR, 32'h3);
    rd("status clr", `RCTD_ISTAT_ADDR, 32'h0);
    chk("irq clr", 32'h0, irq);
    $display("test sleep done");
    print_verdict;
  end
endmodule // rctd_regs_tb_top
